// file: dmapc_cfg.svh
`ifndef DMAPC_CFG_SVH
`define DMAPC_CFG_SVH

`define DMAPC_ADDR_W        12
`define DMAPC_OFF_SRC_IDX   12'h000
`define DMAPC_OFF_DST_IDX   12'h004
`define DMAPC_OFF_CELL_SIZE 12'h008
`define DMAPC_OFF_CELL_PROG 12'h00c
`define DMAPC_OFF_PATTERN   12'h010
`define DMAPC_OFF_CTRL      12'h014
`define DMAPC_OFF_STATUS    12'h018
`define DMAPC_OFF_MASK      12'h01c

`define DMAPC_CTRL_PAT_EN   0
`define DMAPC_CTRL_PAT_TWO  1
`define DMAPC_FLAG_CELL     2
`define DMAPC_FLAG_BLOCK    3
`define DMAPC_FLAG_HALF     4

`define DMAPC_IDX_RST       16'h0000
`define DMAPC_SIZE_RST      16'h0000
`define DMAPC_PAT_RST       16'h0000
`define DMAPC_CTRL_RST      2'h0
`define DMAPC_MASK_RST      5'h00
`define DMAPC_FULL_LEN      17'h10000

`endif

// file: dmapc_pkg.sv
package dmapc_pkg;

   typedef enum logic [8:0] {
      reg_none      = 9'h001,
      reg_src_idx   = 9'h002,
      reg_dst_idx   = 9'h004,
      reg_cell_size = 9'h008,
      reg_cell_prog = 9'h010,
      reg_pattern   = 9'h020,
      reg_ctrl      = 9'h040,
      reg_status    = 9'h080,
      reg_mask      = 9'h100
   } dmapc_reg_e;

   typedef struct packed {
      logic       cell_start;
      logic       rd;
      logic       wr;
      logic [7:0] data;
   } dmapc_beat_s;

   typedef struct packed {
      logic pattern_hit;
      logic dst_half;
      logic block_done;
      logic cell_done;
   } dmapc_evt_s;

endpackage : dmapc_pkg

// file: dmapc_idx_cnt.sv
`timescale 1ns/1ps
`include "dmapc_cfg.svh"

module dmapc_idx_cnt (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   input  wire logic        step,
   input  wire logic        clear,
   input  wire logic [15:0] length,
   output logic      [15:0] index
);

   // A length of zero stands for 65,536 bytes, so the plain 16-bit wrap covers it.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         index <= `DMAPC_IDX_RST;
      else if (ce)
      begin
         if (clear)
            index <= `DMAPC_IDX_RST;
         else if (step && (index == length - 16'h0001))
            index <= `DMAPC_IDX_RST;
         else if (step)
            index <= index + 16'h0001;
      end
   end

endmodule : dmapc_idx_cnt

// file: dmapc_flag.sv
`timescale 1ns/1ps

module dmapc_flag (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic ce,
   input  wire logic set,
   input  wire logic clr,
   output logic      q
);

   // Setting takes priority so an event in the clearing cycle is kept.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         q <= 1'b0;
      else if (ce)
      begin
         if (set)
            q <= 1'b1;
         else if (clr)
            q <= 1'b0;
      end
   end

endmodule : dmapc_flag

// file: dmapc_top.sv
// Notes on behaviour
// - Read-only 16-bit source byte index, reset zero.
// - Read-only 16-bit destination byte index, reset zero.
// - Writable 16-bit cell size, bytes per event.
// - Cell size zero means 65,536 bytes.
// - Read-only cell progress, bytes since cell start or match.
// - Pattern match clears source index and progress.
// - Match value used only in pattern mode.
// - Upper sixteen bits read as zero.
// - Cell-done flag after cell size bytes.
// - Block-done on larger length or match.
// - Destination-half flag at half destination length.
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "dmapc_cfg.svh"

module dmapc_top (
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   input  wire logic                      ce,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [`DMAPC_ADDR_W-1:0]  paddr,
   input  wire logic [31:0]               pwdata,
   output logic      [31:0]               prdata,
   output logic                           pready,
   output logic                           pslverr,
   input  wire dmapc_pkg::dmapc_beat_s    beat,
   input  wire logic [15:0]               src_length,
   input  wire logic [15:0]               dst_length,
   output dmapc_pkg::dmapc_evt_s          evt,
   output logic                           irq
);

   dmapc_pkg::dmapc_reg_e sel;
   logic [15:0] src_byte_index;
   logic [15:0] dst_byte_index;
   logic [15:0] cell_byte_count;
   logic [15:0] cell_progress;
   logic [15:0] match_pattern;
   logic [1:0]  ctrl;
   logic [4:0]  mask;
   logic [4:0]  status;
   logic [16:0] blk_cnt;
   logic [7:0]  prev_byte;
   logic        prev_valid;
   logic [31:0] rd_mux;
   logic        wr_acc;
   logic        rd_setup;
   logic [16:0] cell_len;
   logic [16:0] src_len;
   logic [16:0] dst_len;
   logic [16:0] blk_len;
   logic [15:0] dst_half_pt;
   logic        match;
   logic        cell_end;
   logic        block_end;
   logic        half_hit;

   // Address decode.
   always_comb
   begin
      if (paddr == `DMAPC_OFF_SRC_IDX)
         sel = dmapc_pkg::reg_src_idx;
      else if (paddr == `DMAPC_OFF_DST_IDX)
         sel = dmapc_pkg::reg_dst_idx;
      else if (paddr == `DMAPC_OFF_CELL_SIZE)
         sel = dmapc_pkg::reg_cell_size;
      else if (paddr == `DMAPC_OFF_CELL_PROG)
         sel = dmapc_pkg::reg_cell_prog;
      else if (paddr == `DMAPC_OFF_PATTERN)
         sel = dmapc_pkg::reg_pattern;
      else if (paddr == `DMAPC_OFF_CTRL)
         sel = dmapc_pkg::reg_ctrl;
      else if (paddr == `DMAPC_OFF_STATUS)
         sel = dmapc_pkg::reg_status;
      else if (paddr == `DMAPC_OFF_MASK)
         sel = dmapc_pkg::reg_mask;
      else
         sel = dmapc_pkg::reg_none;
   end

   // The slave answers in the first access cycle unless the block is frozen.
   assign pready   = ce;
   assign pslverr  = psel && penable && (sel == dmapc_pkg::reg_none);
   assign wr_acc   = ce && psel && penable && pwrite;
   assign rd_setup = ce && psel && !penable && !pwrite;

   always_comb
   begin
      rd_mux = 32'h0000_0000;
      if (sel == dmapc_pkg::reg_src_idx)
         rd_mux = {16'h0000, src_byte_index};
      else if (sel == dmapc_pkg::reg_dst_idx)
         rd_mux = {16'h0000, dst_byte_index};
      else if (sel == dmapc_pkg::reg_cell_size)
         rd_mux = {16'h0000, cell_byte_count};
      else if (sel == dmapc_pkg::reg_cell_prog)
         rd_mux = {16'h0000, cell_progress};
      else if (sel == dmapc_pkg::reg_pattern)
         rd_mux = {16'h0000, match_pattern};
      else if (sel == dmapc_pkg::reg_ctrl)
         rd_mux = {30'h0000_0000, ctrl};
      else if (sel == dmapc_pkg::reg_status)
         rd_mux = {27'h000_0000, status};
      else if (sel == dmapc_pkg::reg_mask)
         rd_mux = {27'h000_0000, mask};
   end

   // Read data is caught in the setup cycle so it comes from a flip-flop.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (rd_setup)
         prdata <= rd_mux;
   end

   // Software-written registers.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cell_byte_count <= `DMAPC_SIZE_RST;
      else if (wr_acc && (sel == dmapc_pkg::reg_cell_size))
         cell_byte_count <= pwdata[15:0];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         match_pattern <= `DMAPC_PAT_RST;
      else if (wr_acc && (sel == dmapc_pkg::reg_pattern))
         match_pattern <= pwdata[15:0];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl <= `DMAPC_CTRL_RST;
      else if (wr_acc && (sel == dmapc_pkg::reg_ctrl))
         ctrl <= pwdata[1:0];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         mask <= `DMAPC_MASK_RST;
      else if (wr_acc && (sel == dmapc_pkg::reg_mask))
         mask <= pwdata[4:0];
   end

   // Lengths of zero stand for the full 65,536 bytes.
   assign cell_len    = (cell_byte_count == 16'h0000) ? `DMAPC_FULL_LEN
                                                     : {1'b0, cell_byte_count};
   assign src_len     = (src_length == 16'h0000) ? `DMAPC_FULL_LEN : {1'b0, src_length};
   assign dst_len     = (dst_length == 16'h0000) ? `DMAPC_FULL_LEN : {1'b0, dst_length};
   assign blk_len     = (src_len > dst_len) ? src_len : dst_len;
   assign dst_half_pt = dst_len[16:1];

   // Pattern compare looks only at written bytes, and only in pattern mode.
   always_comb
   begin
      match = 1'b0;
      if (beat.wr && ctrl[`DMAPC_CTRL_PAT_EN])
      begin
         if (ctrl[`DMAPC_CTRL_PAT_TWO])
            match = prev_valid && ({prev_byte, beat.data} == match_pattern);
         else
            match = (beat.data == match_pattern[7:0]);
      end
   end

   assign cell_end  = beat.wr && !beat.cell_start
                      && (({1'b0, cell_progress} + 17'h00001) == cell_len);
   assign block_end = beat.wr && ((blk_cnt + 17'h00001) == blk_len);
   assign half_hit  = beat.wr && ((dst_byte_index + 16'h0001) == dst_half_pt);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prev_byte  <= 8'h00;
         prev_valid <= 1'b0;
      end
      else if (ce)
      begin
         if (match || block_end)
            prev_valid <= 1'b0;
         else if (beat.wr)
         begin
            prev_byte  <= beat.data;
            prev_valid <= 1'b1;
         end
      end
   end

   // Bytes moved in the current block; a match ends the block early.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         blk_cnt <= 17'h00000;
      else if (ce)
      begin
         if (match || block_end)
            blk_cnt <= 17'h00000;
         else if (beat.wr)
            blk_cnt <= blk_cnt + 17'h00001;
      end
   end

   // Progress wraps to zero after 65,536 bytes with no cell start or match, whatever the cell size.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cell_progress <= `DMAPC_IDX_RST;
      else if (ce)
      begin
         if (match)
            cell_progress <= `DMAPC_IDX_RST;
         else if (beat.cell_start)
            cell_progress <= {15'h0000, beat.wr};
         else if (beat.wr)
            cell_progress <= cell_progress + 16'h0001;
      end
   end

   dmapc_idx_cnt u_src_idx (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .step    (beat.rd),
      .clear   (match),
      .length  (src_length),
      .index   (src_byte_index)
   );

   dmapc_idx_cnt u_dst_idx (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .step    (beat.wr),
      .clear   (1'b0),
      .length  (dst_length),
      .index   (dst_byte_index)
   );

   dmapc_flag u_cell_flag (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .set     (cell_end),
      .clr     (wr_acc && (sel == dmapc_pkg::reg_status) && pwdata[`DMAPC_FLAG_CELL]),
      .q       (status[`DMAPC_FLAG_CELL])
   );

   dmapc_flag u_block_flag (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .set     (block_end || match),
      .clr     (wr_acc && (sel == dmapc_pkg::reg_status) && pwdata[`DMAPC_FLAG_BLOCK]),
      .q       (status[`DMAPC_FLAG_BLOCK])
   );

   dmapc_flag u_half_flag (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .set     (half_hit),
      .clr     (wr_acc && (sel == dmapc_pkg::reg_status) && pwdata[`DMAPC_FLAG_HALF]),
      .q       (status[`DMAPC_FLAG_HALF])
   );

   assign status[1:0] = 2'h0;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         evt <= '0;
      else if (ce)
      begin
         evt.cell_done   <= cell_end;
         evt.block_done  <= block_end || match;
         evt.dst_half    <= half_hit;
         evt.pattern_hit <= match;
      end
   end

   assign irq = |(status & mask);

   property p_src_ro;
      @(posedge pclk) disable iff (!presetn)
      wr_acc && (sel == dmapc_pkg::reg_src_idx) && !beat.rd && !match
      |=> $stable(src_byte_index);
   endproperty
   a_src_ro: assert property (p_src_ro) else $error("source index changed by write");

   property p_dst_step;
      @(posedge pclk) disable iff (!presetn)
      ce && beat.wr && (dst_byte_index != dst_length - 16'h0001)
      |=> dst_byte_index == $past(dst_byte_index) + 16'h0001;
   endproperty
   a_dst_step: assert property (p_dst_step) else $error("destination index did not step");

   property p_size_write;
      @(posedge pclk) disable iff (!presetn)
      wr_acc && (sel == dmapc_pkg::reg_cell_size) |=> cell_byte_count == $past(pwdata[15:0]);
   endproperty
   a_size_write: assert property (p_size_write) else $error("cell size not stored");

   property p_zero_size;
      @(posedge pclk) disable iff (!presetn)
      ce && (cell_byte_count == 16'h0000) && beat.wr && !beat.cell_start
      && (cell_progress == 16'h00fe) |=> !evt.cell_done;
   endproperty
   a_zero_size: assert property (p_zero_size) else $error("zero cell size ended early");

   property p_match_clear;
      @(posedge pclk) disable iff (!presetn)
      ce && match |=> (src_byte_index == 16'h0000) && (cell_progress == 16'h0000)
                      && evt.block_done;
   endproperty
   a_match_clear: assert property (p_match_clear) else $error("match did not clear");

   property p_pat_off;
      @(posedge pclk) disable iff (!presetn)
      !ctrl[`DMAPC_CTRL_PAT_EN] |-> !match;
   endproperty
   a_pat_off: assert property (p_pat_off) else $error("match outside pattern mode");

   property p_upper_zero;
      @(posedge pclk) disable iff (!presetn)
      psel && penable && !pwrite && pready && (sel != dmapc_pkg::reg_none)
      |-> prdata[31:16] == 16'h0000;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper read bits not zero");

   property p_cell_done;
      @(posedge pclk) disable iff (!presetn)
      ce && cell_end |=> status[`DMAPC_FLAG_CELL] && evt.cell_done;
   endproperty
   a_cell_done: assert property (p_cell_done) else $error("cell flag not set");

   property p_half;
      @(posedge pclk) disable iff (!presetn)
      ce && beat.wr && (dst_byte_index + 16'h0001 == dst_half_pt) |=> status[`DMAPC_FLAG_HALF];
   endproperty
   a_half: assert property (p_half) else $error("half flag not set");

   property p_src_wrap;
      @(posedge pclk) disable iff (!presetn)
      ce && beat.rd && !match && (src_byte_index == src_length - 16'h0001)
      |=> src_byte_index == 16'h0000;
   endproperty
   a_src_wrap: assert property (p_src_wrap) else $error("source index did not wrap");

   property p_cell_restart;
      @(posedge pclk) disable iff (!presetn)
      ce && beat.cell_start && !beat.wr |=> cell_progress == 16'h0000;
   endproperty
   a_cell_restart: assert property (p_cell_restart) else $error("progress not restarted");

   property p_irq;
      @(posedge pclk) disable iff (!presetn)
      ce && (block_end || match) && mask[`DMAPC_FLAG_BLOCK]
      |=> status[`DMAPC_FLAG_BLOCK] && irq;
   endproperty
   a_irq: assert property (p_irq) else $error("block flag or interrupt not raised");

endmodule : dmapc_top

// file: dmapc_engine_model.sv
`timescale 1ns/1ps

module dmapc_engine_model (
   input  wire logic              pclk,
   output dmapc_pkg::dmapc_beat_s beat
);
   initial beat = '0;

   // The caller sits on a rising edge and is back on the next one, so beats can run back to back.
   task automatic send(input logic s, input logic r, input logic w, input logic [7:0] d);
      beat <= '{cell_start: s, rd: r, wr: w, data: d};
      @(posedge pclk);
   endtask : send

   // Idle data is inverted so that a stale byte can never pass for a fresh one.
   task automatic idle(input int n);
      beat <= '{cell_start: 1'b0, rd: 1'b0, wr: 1'b0, data: ~beat.data};
      repeat (n) @(posedge pclk);
   endtask : idle
endmodule : dmapc_engine_model

// file: dma_channel_progress_counters_test.sv
`timescale 1ns/1ps
`include "dmapc_cfg.svh"

module dma_channel_progress_counters_test;
   logic                        pclk;
   logic                        presetn;
   logic                        ce;
   logic                        psel;
   logic                        penable;
   logic                        pwrite;
   logic [`DMAPC_ADDR_W-1:0]    paddr;
   logic [31:0]                 pwdata;
   logic [31:0]                 prdata;
   logic                        pready;
   logic                        pslverr;
   dmapc_pkg::dmapc_beat_s      beat;
   logic [15:0]                 src_length;
   logic [15:0]                 dst_length;
   dmapc_pkg::dmapc_evt_s       evt;
   logic                        irq;
   logic [31:0]                 rd;
   logic                        er;
   int                          n_fail = 0;
   int                          samples_checked = 0;
   int                          n_cell = 0, n_block = 0, n_half = 0, n_hit = 0;
   int                          c0, b0, h0, p0;

   dmapc_top dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .beat(beat), .src_length(src_length), .dst_length(dst_length),
      .evt(evt), .irq(irq));

   dmapc_engine_model eng (.pclk(pclk), .beat(beat));

   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // Event pulses last one cycle, so counting them at each edge catches doubles and misses.
   always @(posedge pclk)
   begin
      n_cell  <= n_cell + int'(evt.cell_done);
      n_block <= n_block + int'(evt.block_done);
      n_half  <= n_half + int'(evt.dst_half);
      n_hit   <= n_hit + int'(evt.pattern_hit);
   end

   task automatic tally_and_finish();
      $display("checks %0d, mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("ERROR %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'b1 && k < 20);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         n_fail++;
         $display("ERROR %0t: register bus never answered", $time);
         tally_and_finish();
      end
      else
         @(posedge pclk);
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
      chk({31'h0, er}, 32'h0);
   endtask : rd_chk

   task automatic mark();
      c0 = n_cell;
      b0 = n_block;
      h0 = n_half;
      p0 = n_hit;
   endtask : mark

   task automatic t_reset();
      rd_chk(`DMAPC_OFF_SRC_IDX, 32'h0);
      rd_chk(`DMAPC_OFF_DST_IDX, 32'h0);
      rd_chk(`DMAPC_OFF_CELL_PROG, 32'h0);
      rd_chk(`DMAPC_OFF_CELL_SIZE, 32'h0);
      $display("test reset values: done");
   endtask : t_reset

   task automatic t_regs();
      wr(`DMAPC_OFF_CELL_SIZE, 32'hffff_1234);
      rd_chk(`DMAPC_OFF_CELL_SIZE, 32'h0000_1234);
      wr(`DMAPC_OFF_PATTERN, 32'hbeef_5a5a);
      rd_chk(`DMAPC_OFF_PATTERN, 32'h0000_5a5a);
      wr(`DMAPC_OFF_SRC_IDX, 32'h7);
      wr(`DMAPC_OFF_DST_IDX, 32'h7);
      wr(`DMAPC_OFF_CELL_PROG, 32'h7);
      rd_chk(`DMAPC_OFF_SRC_IDX, 32'h0);
      rd_chk(`DMAPC_OFF_DST_IDX, 32'h0);
      rd_chk(`DMAPC_OFF_CELL_PROG, 32'h0);
      apb(1'b0, 12'h020, 32'h0);
      chk({31'h0, er}, 32'h1);
      chk(rd, 32'h0);
      $display("test register access: done");
   endtask : t_regs

   task automatic t_wrap();
      mark();
      for (int k = 1; k <= 3; k++)
         eng.send(1'b0, 1'b1, 1'b1, 8'(k));
      eng.idle(2);
      chk(n_half - h0, 32'h1);
      chk(n_block - b0, 32'h0);
      rd_chk(`DMAPC_OFF_DST_IDX, 32'h3);
      for (int k = 4; k <= 6; k++)
         eng.send(1'b0, 1'b1, 1'b1, 8'(k));
      eng.idle(2);
      chk(n_block - b0, 32'h1);
      rd_chk(`DMAPC_OFF_SRC_IDX, 32'h2);
      rd_chk(`DMAPC_OFF_DST_IDX, 32'h0);
      $display("test index wrap: done");
   endtask : t_wrap

   task automatic t_cell();
      src_length <= 16'h0010;
      dst_length <= 16'h0010;
      wr(`DMAPC_OFF_CELL_SIZE, 32'h3);
      wr(`DMAPC_OFF_STATUS, 32'h1c);
      wr(`DMAPC_OFF_MASK, 32'h1c);
      mark();
      eng.send(1'b1, 1'b1, 1'b1, 8'h11);
      eng.send(1'b0, 1'b0, 1'b1, 8'h12);
      eng.idle(2);
      chk(n_cell - c0, 32'h0);
      eng.send(1'b0, 1'b0, 1'b1, 8'h13);
      eng.idle(2);
      chk(n_cell - c0, 32'h1);
      chk({31'h0, irq}, 32'h1);
      rd_chk(`DMAPC_OFF_CELL_PROG, 32'h3);
      rd_chk(`DMAPC_OFF_STATUS, 32'h4);
      wr(`DMAPC_OFF_STATUS, 32'h4);
      rd_chk(`DMAPC_OFF_STATUS, 32'h0);
      chk({31'h0, irq}, 32'h0);
      eng.send(1'b1, 1'b0, 1'b1, 8'h14);
      eng.idle(2);
      rd_chk(`DMAPC_OFF_CELL_PROG, 32'h1);
      eng.send(1'b1, 1'b0, 1'b0, 8'h00);
      eng.idle(1);
      rd_chk(`DMAPC_OFF_CELL_PROG, 32'h0);
      $display("test cell count: done");
   endtask : t_cell

   task automatic t_pattern();
      wr(`DMAPC_OFF_PATTERN, 32'h42);
      wr(`DMAPC_OFF_CTRL, 32'h0);
      mark();
      eng.send(1'b0, 1'b1, 1'b1, 8'h42);
      eng.idle(2);
      chk(n_hit - p0, 32'h0);
      wr(`DMAPC_OFF_CTRL, 32'h1);
      eng.send(1'b0, 1'b1, 1'b1, 8'h41);
      eng.send(1'b0, 1'b1, 1'b1, 8'h42);
      eng.idle(2);
      chk(n_hit - p0, 32'h1);
      chk(n_block - b0, 32'h1);
      rd_chk(`DMAPC_OFF_SRC_IDX, 32'h0);
      rd_chk(`DMAPC_OFF_CELL_PROG, 32'h0);
      wr(`DMAPC_OFF_PATTERN, 32'h4142);
      wr(`DMAPC_OFF_CTRL, 32'h3);
      eng.send(1'b0, 1'b1, 1'b1, 8'h41);
      eng.send(1'b0, 1'b1, 1'b1, 8'h42);
      eng.idle(2);
      chk(n_hit - p0, 32'h2);
      rd_chk(`DMAPC_OFF_SRC_IDX, 32'h0);
      $display("test pattern match: done");
   endtask : t_pattern

   // With the enable low every beat must be ignored and the bus must not answer.
   task automatic t_freeze();
      logic [31:0] d0;
      apb(1'b0, `DMAPC_OFF_DST_IDX, 32'h0);
      d0 = rd;
      mark();
      ce <= 1'b0;
      eng.send(1'b1, 1'b1, 1'b1, 8'h42);
      eng.send(1'b0, 1'b1, 1'b1, 8'h41);
      chk({31'h0, pready}, 32'h0);
      eng.idle(1);
      ce <= 1'b1;
      eng.idle(2);
      chk(n_cell - c0 + n_block - b0 + n_half - h0 + n_hit - p0, 32'h0);
      rd_chk(`DMAPC_OFF_SRC_IDX, 32'h0);
      rd_chk(`DMAPC_OFF_DST_IDX, d0);
      rd_chk(`DMAPC_OFF_CELL_PROG, 32'h0);
      $display("test clock enable freeze: done");
   endtask : t_freeze

   task automatic t_big();
      src_length <= 16'h0000;
      dst_length <= 16'h0000;
      wr(`DMAPC_OFF_CTRL, 32'h0);
      wr(`DMAPC_OFF_CELL_SIZE, 32'h0);
      mark();
      for (int k = 0; k < 65535; k++)
         eng.send(k == 0, 1'b0, 1'b1, 8'(k));
      eng.idle(2);
      chk(n_cell - c0, 32'h0);
      rd_chk(`DMAPC_OFF_CELL_PROG, 32'h0000_ffff);
      eng.send(1'b0, 1'b0, 1'b1, 8'hff);
      eng.idle(2);
      chk(n_cell - c0, 32'h1);
      chk(n_half - h0, 32'h1);
      $display("test full cell: done");
   endtask : t_big

   initial
   begin
      presetn    = 1'b0;
      ce         = 1'b1;
      psel       = 1'b0;
      penable    = 1'b0;
      pwrite     = 1'b0;
      paddr      = '0;
      pwdata     = 32'h0;
      src_length = 16'h0004;
      dst_length = 16'h0006;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_regs();
      t_wrap();
      t_cell();
      t_pattern();
      t_freeze();
      t_big();
      tally_and_finish();
   end
endmodule : dma_channel_progress_counters_test
